// ### sfpo_regs.svh
// register offsets, field positions, reset values and timing figures
// for the speed-follow pulse output block; assumes a 200 MHz mclk
`ifndef SFPO_REGS_SVH
`define SFPO_REGS_SVH

`define SFPO_CTRL_OFF      12'h000
`define SFPO_SCAN_OFF      12'h004
`define SFPO_SAMPLE_OFF    12'h008
`define SFPO_SPEED_OFF     12'h00c
`define SFPO_ACC_LO_OFF    12'h010
`define SFPO_ACC_HI_OFF    12'h014
`define SFPO_PROP_OFF      12'h018
`define SFPO_OSPD_LO_OFF   12'h01c
`define SFPO_OSPD_HI_OFF   12'h020
`define SFPO_EMIT_LO_OFF   12'h024
`define SFPO_EMIT_HI_OFF   12'h028

`define SFPO_CTRL_EN_BIT   0
`define SFPO_CTRL_SRC_LSB  1
`define SFPO_STAT_RUN_BIT  0
`define SFPO_STAT_REF_BIT  1

`define SFPO_SAMPLE_RST    16'h0001
`define SFPO_PROP_RST      16'h0064
`define SFPO_SAMPLE_MIN1   16'h0001
`define SFPO_SAMPLE_MIN2   16'h0002
`define SFPO_SAMPLE_MAX    16'h0064
`define SFPO_PROP_MIN      16'h0001
`define SFPO_PROP_MAX      16'h2710
`define SFPO_SPEED_MAX     32'h00002710
`define SFPO_OSPD_MAX      32'h000186a0
`define SFPO_PERCENT       32'h00000064

`define SFPO_CLK_MHZ       200
`define SFPO_CLK_HZ        40'd200000000
`define SFPO_IDLE_MS       1000

`endif

// ### sfpo_pkg.sv
// types shared by the speed-follow pulse output block
// assumes sfpo_regs.svh carries the numeric constants
package sfpo_pkg;
   typedef enum logic [1:0] {
      SFPO_SRC_A_LOW,
      SFPO_SRC_B_LOW,
      SFPO_SRC_A_HIGH,
      SFPO_SRC_B_HIGH
   } sfpo_src_t;

   typedef enum logic {
      SFPO_IDLE,
      SFPO_RUN
   } sfpo_state_t;
endpackage

// ### sfpo_speed_follow.sv
// speed-follow pulse output: samples an input pulse rate, scales it by a
// percentage and drives a matching pulse train; APB slave, one clock
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "sfpo_regs.svh"

// Function
// [RL1] source a_low: count that input, drive pulse_output_low only
// [RL2] source b_low: a_low/b_low as A/B, pulse and direction low outputs
// [RL3] source a_high: count that input, drive pulse_output_high only
// [RL4] source b_high: a_high/b_high as A/B, pulse and direction high outputs
// [RL5] refuse start when inputs or outputs already claimed by other functions
// [RL6] two-phase input always counts every edge of both phases; here a change of both phases in one cycle counts nothing
// [RL7] emitted pulse count words refresh only on a scan
// [RL8] new speed sample each time sample-time pulses have arrived
// [RL9] sample time 1..100 single-phase, 2..100 two-phase
// [RL10] out-of-range sample time clamped to nearer limit
// [RL11] new sample time applied only at the next scan
// [RL12] sampled speed read-only signed word in Hz, within +-10 kHz
// [RL13] read-only 32-bit accumulated input count over two words
// [RL14] software picks larger sample time for faster inputs
// [RL15] proportion 1..10000 percent, out-of-range clamped
// [RL16] new proportion applied only at the next scan
// [RL17] output speed signed 32-bit Hz, within +-100 kHz, high word third
// [RL18] output speed is sampled speed times proportion percent
// [RL19] output speed truncated to whole hertz, below one gives none
// [RL20] negative sampled speed gives negative scaled output speed
// [RL21] sampling group: sample time, speed, two count words
// [RL22] output group: proportion, then two output speed words
// [RL23] direction from output speed sign, pulse rate from magnitude
// [RL24] speed is signed count over interval divided by its duration
module sfpo_speed_follow #(
   parameter int unsigned IDLE_CYCLES = `SFPO_IDLE_MS * `SFPO_CLK_MHZ * 1000
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic counter_input_a_low,
   input wire logic counter_input_b_low,
   input wire logic counter_input_a_high,
   input wire logic counter_input_b_high,
   input wire logic hsc_claim_low,
   input wire logic hsc_claim_high,
   input wire logic pout_claim_low,
   input wire logic pout_claim_high,
   output logic pulse_output_low,
   output logic direction_output_low,
   output logic pulse_output_high,
   output logic direction_output_high
);
   import sfpo_pkg::*;

   function automatic logic [15:0] sfpo_clamp(input logic [15:0] v,
                                              input logic [15:0] lo,
                                              input logic [15:0] hi);
      // values are signed words so a negative entry clamps low
      if ($signed(v) < $signed(lo)) begin
         return lo;
      end else if ($signed(v) > $signed(hi)) begin
         return hi;
      end else begin
         return v;
      end
   endfunction

   logic [3:0] sync1_q, sync2_q, sync3_q, filt_q, prev_q;
   logic [2:0] ctrl_q;
   logic [15:0] sample_pend_q, prop_pend_q, sample_act_q, prop_act_q;
   sfpo_state_t state_q;
   sfpo_src_t src_q;
   logic refused_q;
   logic [15:0] speed_q;
   logic [31:0] acc_cnt_q, ospd_q, emit_cnt_q, emit_view_q;
   logic signed [8:0] int_cnt_q;
   logic [31:0] cyc_q;
   logic div_busy_q, div_neg_q;
   logic [5:0] div_n_q;
   logic [39:0] div_num_q;
   logic [32:0] div_rem_q;
   logic [31:0] div_den_q;
   logic [31:0] phase_q;
   logic pulse_q, dir_q;

   logic wr_en, scan, claimed, quad, a_n, b_n, a_p, b_p, step, up;
   logic [8:0] cnt_mag;
   logic signed [8:0] int_cnt_d;
   logic sample_hit;
   logic [32:0] rem_sh;
   logic [39:0] q_fin;
   logic [31:0] spd_mag, ospd_mag, in_mag;
   logic [63:0] prod;
   logic [31:0] phase_sum;

   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign scan = wr_en && paddr == `SFPO_SCAN_OFF && pwdata[0];

   // three-stage input capture; a level counts once stages two and three agree
   always_ff @(posedge mclk) begin
      if (reset) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
         sync3_q <= 4'h0;
         filt_q <= 4'h0;
         prev_q <= 4'h0;
      end else begin
         sync1_q <= {counter_input_b_high, counter_input_a_high,
                     counter_input_b_low, counter_input_a_low};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         filt_q <= (~(sync2_q ^ sync3_q) & sync3_q) |
                   ((sync2_q ^ sync3_q) & filt_q);
         prev_q <= filt_q;
      end
   end

   // software-side registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         ctrl_q <= 3'h0;
         sample_pend_q <= `SFPO_SAMPLE_RST;
         prop_pend_q <= `SFPO_PROP_RST;
      end else if (wr_en) begin
         if (paddr == `SFPO_CTRL_OFF) begin
            ctrl_q <= pwdata[2:0];
         end else if (paddr == `SFPO_SAMPLE_OFF) begin
            sample_pend_q <= pwdata[15:0];
         end else if (paddr == `SFPO_PROP_OFF) begin
            prop_pend_q <= pwdata[15:0];
         end
      end
   end

   assign claimed = ctrl_q[`SFPO_CTRL_SRC_LSB + 1] ?
                    (hsc_claim_high | pout_claim_high) :
                    (hsc_claim_low | pout_claim_low);

   // start and parameter hand-over happen on a scan; clearing the enable bit stops at once
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_q <= SFPO_IDLE;
         src_q <= SFPO_SRC_A_LOW;
         refused_q <= 1'b0;
         sample_act_q <= `SFPO_SAMPLE_RST;
         prop_act_q <= `SFPO_PROP_RST;
      end else if (!ctrl_q[`SFPO_CTRL_EN_BIT]) begin
         state_q <= SFPO_IDLE;
      end else if (scan) begin
         case (state_q)
            SFPO_IDLE: begin
               if (claimed) begin
                  refused_q <= 1'b1; // RL5
               end else begin
                  state_q <= SFPO_RUN;
                  refused_q <= 1'b0;
                  src_q <= sfpo_src_t'(ctrl_q[2:1]); // RL1 RL2 RL3 RL4
               end
            end
            default: begin
               state_q <= SFPO_RUN;
            end
         endcase
         // two-phase mode needs at least two edges per sample
         sample_act_q <= sfpo_clamp(sample_pend_q,
            ctrl_q[`SFPO_CTRL_SRC_LSB] ? `SFPO_SAMPLE_MIN2 : `SFPO_SAMPLE_MIN1,
            `SFPO_SAMPLE_MAX); // RL9 RL10 RL11
         prop_act_q <= sfpo_clamp(prop_pend_q, `SFPO_PROP_MIN,
                                  `SFPO_PROP_MAX); // RL15 RL16
      end
   end

   // edge decode of the selected input pair
   always_comb begin
      quad = src_q == SFPO_SRC_B_LOW || src_q == SFPO_SRC_B_HIGH;
      a_n = src_q[1] ? filt_q[2] : filt_q[0];
      b_n = src_q[1] ? filt_q[3] : filt_q[1];
      a_p = src_q[1] ? prev_q[2] : prev_q[0];
      b_p = src_q[1] ? prev_q[3] : prev_q[1];
      if (quad) begin
         // every edge of either phase counts; a double change is noise
         step = (a_n ^ a_p) ^ (b_n ^ b_p); // RL6
         up = ~(a_p ^ b_n);
      end else begin
         step = a_n & ~a_p;
         up = 1'b1;
      end
      step = step && state_q == SFPO_RUN;
      int_cnt_d = step ? (up ? int_cnt_q + 9'sd1 : int_cnt_q - 9'sd1)
                       : int_cnt_q;
      cnt_mag = int_cnt_d[8] ? 9'(-int_cnt_d) : 9'(int_cnt_d);
      sample_hit = step && cnt_mag >= sample_act_q[8:0]; // RL8
   end

   // accumulated input count and sampling interval
   always_ff @(posedge mclk) begin
      if (reset) begin
         acc_cnt_q <= 32'h0;
      end else if (step) begin
         acc_cnt_q <= up ? acc_cnt_q + 32'h1 : acc_cnt_q - 32'h1; // RL13
      end
   end

   always_ff @(posedge mclk) begin
      if (reset || state_q != SFPO_RUN) begin
         int_cnt_q <= 9'sd0;
         cyc_q <= 32'h1;
      end else if (sample_hit || cyc_q >= IDLE_CYCLES) begin
         int_cnt_q <= 9'sd0;
         cyc_q <= 32'h1;
      end else begin
         int_cnt_q <= int_cnt_d;
         cyc_q <= cyc_q + 32'h1;
      end
   end

   // restoring divider: |count| * clock rate / interval cycles
   assign rem_sh = {div_rem_q[31:0], div_num_q[39]};
   assign q_fin = {div_num_q[38:0], rem_sh >= {1'b0, div_den_q}};
   always_ff @(posedge mclk) begin
      if (reset) begin
         div_busy_q <= 1'b0;
         div_neg_q <= 1'b0;
         div_n_q <= 6'h0;
         div_num_q <= 40'h0;
         div_rem_q <= 33'h0;
         div_den_q <= 32'h1;
      end else if (div_busy_q) begin
         if (rem_sh >= {1'b0, div_den_q}) begin
            div_rem_q <= rem_sh - {1'b0, div_den_q};
            div_num_q <= {div_num_q[38:0], 1'b1};
         end else begin
            div_rem_q <= rem_sh;
            div_num_q <= {div_num_q[38:0], 1'b0};
         end
         div_n_q <= div_n_q - 6'h1;
         div_busy_q <= div_n_q != 6'h1;
      end else if (sample_hit) begin
         // a sample landing during a divide is dropped; pulse rate is far
         // below the divide rate so this never happens in range
         div_busy_q <= 1'b1;
         div_n_q <= 6'd40;
         div_neg_q <= int_cnt_d[8];
         div_num_q <= 40'(cnt_mag) * `SFPO_CLK_HZ; // RL24
         div_rem_q <= 33'h0;
         div_den_q <= cyc_q;
      end
   end

   assign spd_mag = q_fin[39:32] != 8'h0 || q_fin[31:0] > `SFPO_SPEED_MAX ?
                    `SFPO_SPEED_MAX : q_fin[31:0];

   always_ff @(posedge mclk) begin
      if (reset || state_q != SFPO_RUN) begin
         speed_q <= 16'h0;
      end else if (cyc_q >= IDLE_CYCLES) begin
         speed_q <= 16'h0;
      end else if (div_busy_q && div_n_q == 6'h1) begin
         // last quotient bit is folded in here
         speed_q <= div_neg_q ? 16'(-spd_mag) : spd_mag[15:0]; // RL12
      end
   end

   // scaled output speed, truncated toward zero and signed like the input
   always_comb begin
      in_mag = speed_q[15] ? 32'(16'(-speed_q)) : 32'(speed_q);
      prod = 64'(in_mag) * 64'(prop_act_q); // RL18
      ospd_mag = 32'(prod / 64'(`SFPO_PERCENT)); // RL19
      if (ospd_mag > `SFPO_OSPD_MAX) begin
         ospd_mag = `SFPO_OSPD_MAX;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset || state_q != SFPO_RUN) begin
         ospd_q <= 32'h0;
      end else begin
         ospd_q <= speed_q[15] ? 32'(-ospd_mag) : ospd_mag; // RL17 RL20
      end
   end

   // pulse generator: phase accumulator toggles at twice the output rate
   assign phase_sum = phase_q + {ospd_mag[30:0], 1'b0};
   always_ff @(posedge mclk) begin
      if (reset || state_q != SFPO_RUN || ospd_mag == 32'h0) begin
         phase_q <= 32'h0;
         pulse_q <= 1'b0;
      end else if (phase_sum >= `SFPO_CLK_HZ) begin
         phase_q <= phase_sum - 32'(`SFPO_CLK_HZ);
         pulse_q <= ~pulse_q; // RL23
      end else begin
         phase_q <= phase_sum;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         dir_q <= 1'b0;
      end else begin
         dir_q <= quad && state_q == SFPO_RUN && !speed_q[15]; // RL23
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         emit_cnt_q <= 32'h0;
         emit_view_q <= 32'h0;
      end else begin
         if (pulse_q == 1'b0 && phase_sum >= `SFPO_CLK_HZ &&
             state_q == SFPO_RUN && ospd_mag != 32'h0) begin
            emit_cnt_q <= emit_cnt_q + 32'h1;
         end
         if (scan) begin
            emit_view_q <= emit_cnt_q; // RL7
         end
      end
   end

   // pin mapping per selected source
   always_ff @(posedge mclk) begin
      if (reset) begin
         pulse_output_low <= 1'b0;
         direction_output_low <= 1'b0;
         pulse_output_high <= 1'b0;
         direction_output_high <= 1'b0;
      end else begin
         pulse_output_low <= !src_q[1] && pulse_q; // RL1 RL2
         direction_output_low <= src_q == SFPO_SRC_B_LOW && dir_q; // RL2
         pulse_output_high <= src_q[1] && pulse_q; // RL3 RL4
         direction_output_high <= src_q == SFPO_SRC_B_HIGH && dir_q; // RL4
      end
   end

   // read decode; unmapped addresses answer with an error and zero data
   always_comb begin
      prdata = 32'h0;
      pslverr = 1'b0;
      if (paddr == `SFPO_CTRL_OFF) begin
         prdata = {29'h0, ctrl_q};
      end else if (paddr == `SFPO_SCAN_OFF) begin
         prdata = {30'h0, refused_q, state_q == SFPO_RUN};
      end else if (paddr == `SFPO_SAMPLE_OFF) begin
         prdata = {16'h0, sample_pend_q}; // RL21
      end else if (paddr == `SFPO_SPEED_OFF) begin
         prdata = {16'h0, speed_q}; // RL21
      end else if (paddr == `SFPO_ACC_LO_OFF) begin
         prdata = {16'h0, acc_cnt_q[15:0]}; // RL21
      end else if (paddr == `SFPO_ACC_HI_OFF) begin
         prdata = {16'h0, acc_cnt_q[31:16]}; // RL21
      end else if (paddr == `SFPO_PROP_OFF) begin
         prdata = {16'h0, prop_pend_q}; // RL22
      end else if (paddr == `SFPO_OSPD_LO_OFF) begin
         prdata = {16'h0, ospd_q[15:0]}; // RL22
      end else if (paddr == `SFPO_OSPD_HI_OFF) begin
         prdata = {16'h0, ospd_q[31:16]}; // RL22
      end else if (paddr == `SFPO_EMIT_LO_OFF) begin
         prdata = {16'h0, emit_view_q[15:0]};
      end else if (paddr == `SFPO_EMIT_HI_OFF) begin
         prdata = {16'h0, emit_view_q[31:16]};
      end else begin
         pslverr = psel & penable;
      end
   end
endmodule

// ### sfpo_speed_follow_sva.sv
// assertions for the speed-follow pulse output block
// bound to sfpo_speed_follow; watches its top-level ports only
`timescale 1ns/1ps
`include "sfpo_regs.svh"
module sfpo_speed_follow_sva #(
   parameter int unsigned IDLE_CYCLES = 20000
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic pulse_output_low,
   input wire logic direction_output_low,
   input wire logic pulse_output_high,
   input wire logic direction_output_high
);
   logic [2:0] ctrl_q;
   logic [31:0] emit_q;
   logic emit_ok_q;
   logic acc;
   assign acc = psel && penable && pready;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (reset);
   always_ff @(posedge mclk) begin
      if (reset) begin
         ctrl_q <= 3'h0;
      end else if (acc && pwrite && paddr == `SFPO_CTRL_OFF) begin
         ctrl_q <= pwdata[2:0];
      end
   end
   // any scan write may refresh the snapshot, so it forgets the last read
   always_ff @(posedge mclk) begin
      if (reset || (acc && pwrite && paddr == `SFPO_SCAN_OFF)) begin
         emit_ok_q <= 1'b0;
      end else if (acc && !pwrite && paddr == `SFPO_EMIT_LO_OFF) begin
         emit_ok_q <= 1'b1;
      end
   end
   always_ff @(posedge mclk) begin
      if (acc && !pwrite && paddr == `SFPO_EMIT_LO_OFF) begin
         emit_q <= prdata;
      end
   end
   sequence s_rd(a);
      acc && !pwrite && paddr == a;
   endsequence
   property p_mapped;
      acc && paddr <= `SFPO_EMIT_HI_OFF && paddr[1:0] == 2'h0 |-> !pslverr;
   endproperty
   property p_unmapped;
      acc && paddr > `SFPO_EMIT_HI_OFF |-> pslverr && prdata == 32'h0;
   endproperty
   property p_dir_low;
      $rose(direction_output_low) |-> ctrl_q == 3'h3 || $past(ctrl_q) == 3'h3;
   endproperty
   property p_dir_high;
      $rose(direction_output_high) |-> ctrl_q == 3'h7 || $past(ctrl_q) == 3'h7;
   endproperty
   property p_pls_low;
      $rose(pulse_output_low) |-> !ctrl_q[2] || !$past(ctrl_q[2]);
   endproperty
   property p_pls_high;
      $rose(pulse_output_high) |-> ctrl_q[2] || $past(ctrl_q[2]);
   endproperty
   property p_emit;
      s_rd(`SFPO_EMIT_LO_OFF) ##0 emit_ok_q |-> prdata == emit_q;
   endproperty
   property p_speed_rng;
      s_rd(`SFPO_SPEED_OFF) |-> $signed(prdata[15:0]) <= 16'sd10000
         && $signed(prdata[15:0]) >= -16'sd10000;
   endproperty
   property p_ospd_rng;
      s_rd(`SFPO_OSPD_HI_OFF) |-> prdata[15:0] inside
         {16'h0000, 16'h0001, 16'hffff, 16'hfffe};
   endproperty
   a_mapped: assert property (p_mapped)
      else $error("mapped access flagged as error");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not flagged");
   a_dir_low: assert property (p_dir_low)
      else $error("low direction rose outside low quad mode");
   a_dir_high: assert property (p_dir_high)
      else $error("high direction rose outside high quad mode");
   a_pls_low: assert property (p_pls_low)
      else $error("low pulse output active for a high source");
   a_pls_high: assert property (p_pls_high)
      else $error("high pulse output active for a low source");
   a_emit: assert property (p_emit)
      else $error("emitted count changed without a scan");
   a_speed_rng: assert property (p_speed_rng)
      else $error("sampled speed out of range");
   a_ospd_rng: assert property (p_ospd_rng)
      else $error("output speed out of range");
endmodule
bind sfpo_speed_follow sfpo_speed_follow_sva #(.IDLE_CYCLES(IDLE_CYCLES)) i_sva (
   .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pulse_output_low(pulse_output_low),
   .direction_output_low(direction_output_low),
   .pulse_output_high(pulse_output_high),
   .direction_output_high(direction_output_high)
);

// ### sfpo_enc_model.sv
// quadrature encoder model for one counter input pair
// assumes the bench holds run low when no encoder motion is wanted
`timescale 1ns/1ps
module sfpo_enc_model (
   input wire logic mclk,
   input wire logic run,
   input wire logic rev,
   input wire logic [15:0] step_cyc,
   output logic pin_a,
   output logic pin_b
);
   logic [15:0] cnt_q = 16'h0;
   logic [1:0] ph_q = 2'h0;
   always_ff @(posedge mclk) begin
      if (!run) begin
         cnt_q <= 16'h0;
      end else if (cnt_q + 16'h1 >= step_cyc) begin
         cnt_q <= 16'h0;
         ph_q <= rev ? ph_q - 2'h1 : ph_q + 2'h1;
      end else begin
         cnt_q <= cnt_q + 16'h1;
      end
   end
   // forward motion: a leads b by a quarter cycle
   assign pin_a = ph_q == 2'h1 || ph_q == 2'h2;
   assign pin_b = ph_q[1];
endmodule

// ### tb_top.sv
// self-checking bench for the speed-follow pulse output block
// assumes a zero-wait apb slave and one encoder model on either pair
`timescale 1ns/1ps
`include "sfpo_regs.svh"
module tb_top;
   typedef struct {
      logic [31:0] val;
      logic [31:0] mask;
      logic err;
   } sfpo_exp_t;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [3:0] claim = 4'h0;
   logic enc_run = 1'b0;
   logic enc_rev = 1'b0;
   logic enc_hi = 1'b0;
   logic enc_a;
   logic enc_b;
   logic pol;
   logic dol;
   logic poh;
   logic doh;
   logic last;
   logic [31:0] p;
   logic [31:0] e;
   int error_cnt = 0;
   int checks_done = 0;
   int cycles = 0;
   int rises;
   int seed = 32'hd7800e62;
   sfpo_exp_t exp_q[$];
   sfpo_exp_t cur;
   always #2.5 mclk = ~mclk;
   sfpo_speed_follow #(.IDLE_CYCLES(20000)) i_sfpo_speed_follow (
      .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .counter_input_a_low(enc_hi ? 1'b0 : enc_a),
      .counter_input_b_low(enc_hi ? 1'b0 : enc_b),
      .counter_input_a_high(enc_hi ? enc_a : 1'b0),
      .counter_input_b_high(enc_hi ? enc_b : 1'b0),
      .hsc_claim_low(claim[0]), .pout_claim_low(claim[1]),
      .hsc_claim_high(claim[2]), .pout_claim_high(claim[3]),
      .pulse_output_low(pol), .direction_output_low(dol),
      .pulse_output_high(poh), .direction_output_high(doh)
   );
   sfpo_enc_model i_sfpo_enc_model (
      .mclk(mclk), .run(enc_run), .rev(enc_rev), .step_cyc(16'd1000),
      .pin_a(enc_a), .pin_b(enc_b)
   );
   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      checks_done++;
      if (got !== want) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] v,
                     input logic [31:0] m, input logic err);
      exp_q.push_back('{v, m, err});
      apb(1'b0, a, 32'h0);
   endtask
   task automatic scan();
      apb(1'b1, `SFPO_SCAN_OFF, 32'h1);
   endtask
   // read results are matched against the oldest note
   always @(posedge mclk) begin
      if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
         cur = exp_q.pop_front();
         chk(prdata & cur.mask, cur.val);
         chk({31'h0, pslverr}, {31'h0, cur.err});
      end
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 100000) begin
         error_cnt++;
         complete_run();
      end
   end
   initial begin
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      rd(`SFPO_SAMPLE_OFF, 32'h1, 32'hffff, 1'b0);
      rd(`SFPO_PROP_OFF, 32'h64, 32'hffff, 1'b0);
      rd(12'h040, 32'h0, 32'hffffffff, 1'b1);
      apb(1'b1, `SFPO_CTRL_OFF, 32'h3);
      for (int i = 0; i < 2; i++) begin
         claim <= 4'h1 << i;
         scan();
         rd(`SFPO_SCAN_OFF, 32'h2, 32'h3, 1'b0);
      end
      apb(1'b1, `SFPO_PROP_OFF, 32'd50);
      apb(1'b1, `SFPO_SAMPLE_OFF, 32'h1);
      enc_run <= 1'b1;
      claim <= 4'hc;
      scan();
      rd(`SFPO_SCAN_OFF, 32'h1, 32'h3, 1'b0);
      repeat (4000) @(posedge mclk);
      rd(`SFPO_SPEED_OFF, 32'h2710, 32'hffff, 1'b0);
      rd(`SFPO_OSPD_LO_OFF, 32'h1388, 32'hffff, 1'b0);
      rd(`SFPO_OSPD_HI_OFF, 32'h0, 32'hffff, 1'b0);
      chk({31'h0, dol}, 32'h1);
      apb(1'b1, `SFPO_SPEED_OFF, $random(seed));
      rd(`SFPO_SPEED_OFF, 32'h2710, 32'hffff, 1'b0);
      apb(1'b1, `SFPO_PROP_OFF, 32'h2710);
      repeat (3000) @(posedge mclk);
      rd(`SFPO_OSPD_LO_OFF, 32'h1388, 32'hffff, 1'b0);
      scan();
      repeat (3000) @(posedge mclk);
      rd(`SFPO_OSPD_LO_OFF, 32'h86a0, 32'hffff, 1'b0);
      rd(`SFPO_OSPD_HI_OFF, 32'h1, 32'hffff, 1'b0);
      rises = 0;
      repeat (20000) begin
         last = pol;
         @(posedge mclk);
         if (pol && !last) rises++;
      end
      chk({31'h0, rises >= 9 && rises <= 11}, 32'h1);
      // pulses keep coming between these reads; the snapshot must not move
      rd(`SFPO_EMIT_LO_OFF, 32'h0, 32'h0, 1'b0);
      repeat (3000) @(posedge mclk);
      rd(`SFPO_EMIT_LO_OFF, 32'h0, 32'h0, 1'b0);
      for (int i = 0; i < 2; i++) begin
         p = i ? 32'd1 + ($unsigned($random(seed)) % 1000) : 32'h0;
         e = (i ? p : 32'd1) * 32'd100;
         apb(1'b1, `SFPO_PROP_OFF, p);
         scan();
         repeat (3000) @(posedge mclk);
         rd(`SFPO_OSPD_LO_OFF, {16'h0, e[15:0]}, 32'hffff, 1'b0);
      end
      enc_rev <= 1'b1;
      claim <= 4'h0;
      repeat (6000) @(posedge mclk);
      e = 32'h0 - e;
      rd(`SFPO_SPEED_OFF, 32'hd8f0, 32'hffff, 1'b0);
      rd(`SFPO_OSPD_LO_OFF, {16'h0, e[15:0]}, 32'hffff, 1'b0);
      rd(`SFPO_OSPD_HI_OFF, {16'h0, e[31:16]}, 32'hffff, 1'b0);
      chk({31'h0, dol}, 32'h0);
      apb(1'b1, `SFPO_CTRL_OFF, 32'h0);
      enc_hi <= 1'b1;
      enc_rev <= 1'b0;
      apb(1'b1, `SFPO_SAMPLE_OFF, 32'h0);
      apb(1'b1, `SFPO_PROP_OFF, 32'h2710);
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, `SFPO_CTRL_OFF, 32'h0);
         apb(1'b1, `SFPO_CTRL_OFF, i ? 32'h7 : 32'h5);
         scan();
         // single mode sees one a rise per four encoder steps, so the
         // first sample may need a whole encoder cycle
         rises = 0;
         repeat (9000) begin
            last = poh;
            @(posedge mclk);
            if (poh && !last) rises++;
         end
         rd(`SFPO_SPEED_OFF, 32'h2710, 32'hffff, 1'b0);
         chk({31'h0, doh}, i);
         chk({31'h0, rises >= 2}, 32'h1);
      end
      complete_run();
   end
endmodule
